// ### qdc_pkg.sv
// Shared constants, field layout and carrier types of the quad converter core.
// Assumes a 24-bit serial frame and four 12-bit channels in two groups.
package qdc_pkg;

    // ****************************************
    // Frame layout
    // ****************************************
    localparam int          FRAME_BITS = 24;
    localparam int          CNT_W      = 5;
    localparam logic [4:0]  FRAME_FULL = 5'h18;
    localparam int          RW_BIT     = 23;
    localparam int          ADDR_HI    = 22;
    localparam int          ADDR_LO    = 19;
    localparam int          DATA_HI    = 11;
    localparam int          DATA_LO    = 0;

    // ****************************************
    // Address map of the serial word
    // ****************************************
    localparam logic [3:0]  ADDR_CMD   = 4'h0;
    localparam logic [1:0]  BANK_DAC   = 2'h1;
    localparam logic [1:0]  BANK_ZERO  = 2'h2;
    localparam logic [1:0]  BANK_GAIN  = 2'h3;

    // ****************************************
    // Command word fields
    // ****************************************
    localparam int          CMD_GAIN_LO = 0;
    localparam int          CMD_LD_BIT  = 8;
    localparam int          CMD_RST_BIT = 9;

    // ****************************************
    // Values after reset, and the bipolar flip mask
    // ****************************************
    localparam logic [11:0] RESET_CODE_BIP = 12'h000;
    localparam logic [11:0] RESET_CODE_UNI = 12'h000;
    localparam logic [8:0]  ZERO_RESET     = 9'h000;
    localparam logic [7:0]  GAIN_RESET     = 8'h00;
    localparam logic [3:0]  GAIN4_RESET    = 4'hF;
    localparam logic [11:0] BIPOLAR_FLIP   = 12'h800;

    typedef enum logic [1:0] {
        QDC_RESET = 2'b01,
        QDC_RUN   = 2'b10
    } qdc_state_e;

    typedef struct packed {
        logic [11:0]       code;
        logic [11:0]       ladder;
        logic signed [8:0] zero;
        logic signed [7:0] gain;
        logic              gain4;
        logic              unipolar;
    } qdc_chan_s;

    typedef struct packed {
        logic [11:0] data;
        logic [3:0]  addr;
        logic        valid;
    } qdc_rdbk_s;

    // Twos complement input becomes offset binary for the ladder
    function automatic logic [11:0] ladder_code(input logic [11:0] c,
                                                input logic        uni);
        return uni ? c : (c ^ BIPOLAR_FLIP);
    endfunction

    function automatic logic [11:0] reset_code(input logic uni);
        return uni ? RESET_CODE_UNI : RESET_CODE_BIP;
    endfunction

endpackage

// ### qdc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter, one per bit.
// Assumes pins are asynchronous to mclk; rstn is synchronous, active low.
`timescale 1ns/100ps
module qdc_pin_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         mclk,   // Core clock
    input  wire logic         rstn,   // Synchronous reset, active low
    input  wire logic [W-1:0] pin,    // Asynchronous inputs
    output logic      [W-1:0] level   // Filtered levels
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_q;
    logic [W-1:0] agree;

    always_ff @(posedge mclk) begin
        s1_q <= pin;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end

    assign agree = ~(s2_q ^ s3_q);

    // Level moves only once the second and third stages agree
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            level_q <= RST_VAL;
        end else begin
            level_q <= (s3_q & agree) | (level_q & ~agree);
        end
    end

    assign level = level_q;

endmodule

// ### qdc_core.sv
// Control core of a quad 12-bit converter: serial frame capture,
// double-buffered channel codes, trims, load and reset handling.
// Assumes the host keeps sclk still while cs_n is high and that cs_n
// stays high for at least six mclk cycles between frames.
`timescale 1ns/100ps
module qdc_core
    import qdc_pkg::*;
(
    input  wire logic                mclk,          // Core clock, 40 MHz
    input  wire logic                rstn,          // Sync reset, active low
    input  wire logic                sclk,          // Serial link clock
    input  wire logic                cs_n,          // Frame select, active low
    input  wire logic                sdi,           // Serial data in
    input  wire logic                load_strobe_n, // Load pin, active low
    input  wire logic                range_mode_a,  // Group A, 1 = unipolar
    input  wire logic                range_mode_b,  // Group B, 1 = unipolar
    output qdc_pkg::qdc_chan_s [3:0] chan_out,      // Per-channel ladder data
    output qdc_pkg::qdc_rdbk_s       readback,      // Read-back word
    output logic                     in_reset       // Core held in reset
);
    import qdc_pkg::*;

    // ****************************************
    // Link domain: shift register and counter
    // ****************************************
    logic [FRAME_BITS-1:0] shift_q;
    logic [CNT_W-1:0]      bit_cnt_q;
    logic [FRAME_BITS-1:0] word_q;
    logic                  word_ok_q;

    always_ff @(negedge sclk) begin
        if (!cs_n) begin
            shift_q <= {shift_q[FRAME_BITS-2:0], sdi};
        end
    end

    // Counter saturates so long frames still count as complete
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt_q <= '0;
        end else if (bit_cnt_q != FRAME_FULL) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    // Snapshot at cs rise; stays still until the next frame ends, so the
    // core may read it once its own copy of cs_n has risen.
    always_ff @(posedge cs_n) begin
        word_q    <= shift_q;
        word_ok_q <= (bit_cnt_q == FRAME_FULL);
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [3:0] pins_f;
    logic       cs_f;
    logic       ld_f;
    logic       uni_a;
    logic       uni_b;

    qdc_pin_sync #(
        .W       (4),
        .RST_VAL (4'hC)
    ) u_sync (
        .mclk  (mclk),
        .rstn  (rstn),
        .pin   ({cs_n, load_strobe_n, range_mode_a, range_mode_b}),
        .level (pins_f)
    );

    assign cs_f  = pins_f[3];
    assign ld_f  = pins_f[2];
    assign uni_a = pins_f[1];
    assign uni_b = pins_f[0];

    function automatic logic chan_uni(input int ch,
                                      input logic ua,
                                      input logic ub);
        return (ch < 2) ? ua : ub;
    endfunction

    // ****************************************
    // Reset and state
    // ****************************************
    qdc_state_e state_q;
    logic       sw_rst_q;
    logic       rst_all;
    logic       cs_prev_q;
    logic       ld_prev_q;

    assign rst_all = !rstn || sw_rst_q;

    always_ff @(posedge mclk) begin
        if (rst_all) begin
            state_q <= QDC_RESET;
        end else begin
            state_q <= QDC_RUN;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cs_prev_q <= 1'b1;
            ld_prev_q <= 1'b1;
        end else begin
            cs_prev_q <= cs_f;
            ld_prev_q <= ld_f;
        end
    end

    // ****************************************
    // Frame decode
    // ****************************************
    logic        cs_rise;
    logic        take;
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [11:0] data;
    logic [3:0]  wr_in;
    logic        wr_cmd;
    logic        ld_fall;
    logic        load_evt;

    assign cs_rise = cs_f && !cs_prev_q;
    // Frames ending while reset is active are thrown away
    assign take    = cs_rise && word_ok_q && (state_q == QDC_RUN)
                     && !rst_all;
    assign addr    = word_q[ADDR_HI:ADDR_LO];
    assign data    = word_q[DATA_HI:DATA_LO];
    assign wr      = take && !word_q[RW_BIT];
    assign rd      = take && word_q[RW_BIT];
    assign wr_cmd  = wr && (addr == ADDR_CMD);
    assign ld_fall = !ld_f && ld_prev_q && !rst_all;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wr_in[i] = wr && (addr[3:2] == BANK_DAC)
                       && (addr[1:0] == 2'(i));
        end
    end

    assign load_evt = ld_fall || (wr_cmd && data[CMD_LD_BIT]);

    // ****************************************
    // Software reset bit
    // ****************************************
    // Held for one cycle, then cleared by the reset it causes
    always_ff @(posedge mclk) begin
        if (rst_all) begin
            sw_rst_q <= 1'b0;
        end else if (wr_cmd && data[CMD_RST_BIT]) begin
            sw_rst_q <= 1'b1;
        end
    end

    // ****************************************
    // Channel registers
    // ****************************************
    logic [11:0]       input_q [4];
    logic [11:0]       latch_q [4];
    logic signed [8:0] zero_q  [4];
    logic signed [7:0] gain_q  [4];
    logic [3:0]        gain4_q;
    logic [3:0]        pend_q;

    always_ff @(posedge mclk) begin
        for (int i = 0; i < 4; i++) begin
            if (rst_all) begin
                input_q[i] <= reset_code(chan_uni(i, uni_a, uni_b));
            end else if (wr_in[i]) begin
                input_q[i] <= data;
            end
        end
    end

    // Channel is loaded on the write itself if the pin is low or a load
    // event coincides; otherwise the pending code waits for a load event.
    always_ff @(posedge mclk) begin
        for (int i = 0; i < 4; i++) begin
            if (rst_all) begin
                latch_q[i] <= reset_code(chan_uni(i, uni_a, uni_b));
            end else if (wr_in[i] && (!ld_f || load_evt)) begin
                latch_q[i] <= data;
            end else if (load_evt && pend_q[i]) begin
                latch_q[i] <= input_q[i];
            end
        end
    end

    // A write in the cycle of a load event is loaded, never lost
    always_ff @(posedge mclk) begin
        for (int i = 0; i < 4; i++) begin
            if (rst_all) begin
                pend_q[i] <= 1'b0;
            end else if (wr_in[i]) begin
                pend_q[i] <= ld_f && !load_evt;
            end else if (load_evt) begin
                pend_q[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        for (int i = 0; i < 4; i++) begin
            if (rst_all) begin
                zero_q[i] <= ZERO_RESET;
                gain_q[i] <= GAIN_RESET;
            end else if (wr && addr[3:2] == BANK_ZERO
                         && addr[1:0] == 2'(i)) begin
                zero_q[i] <= data[8:0];
            end else if (wr && addr[3:2] == BANK_GAIN
                         && addr[1:0] == 2'(i)) begin
                gain_q[i] <= data[7:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst_all) begin
            gain4_q <= GAIN4_RESET;
        end else if (wr_cmd) begin
            gain4_q <= data[CMD_GAIN_LO+3:CMD_GAIN_LO];
        end
    end

    // ****************************************
    // Read-back
    // ****************************************
    logic [11:0] rd_data;
    qdc_rdbk_s   rdbk_q;

    // Trims come back sign-extended, action bits read as zero
    always_comb begin
        rd_data = 12'h000;
        case (addr[3:2])
            2'h0: begin
                if (addr == ADDR_CMD) begin
                    rd_data[CMD_GAIN_LO+3:CMD_GAIN_LO] = gain4_q;
                end
            end
            BANK_DAC: begin
                rd_data = input_q[addr[1:0]];
            end
            BANK_ZERO: begin
                rd_data = {{3{zero_q[addr[1:0]][8]}}, zero_q[addr[1:0]]};
            end
            BANK_GAIN: begin
                rd_data = {{4{gain_q[addr[1:0]][7]}}, gain_q[addr[1:0]]};
            end
            default: begin
                rd_data = 12'h000;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst_all) begin
            rdbk_q <= '0;
        end else if (rd) begin
            rdbk_q.data  <= rd_data;
            rdbk_q.addr  <= addr;
            rdbk_q.valid <= 1'b1;
        end else begin
            rdbk_q.valid <= 1'b0;
        end
    end

    assign readback = rdbk_q;
    assign in_reset = (state_q == QDC_RESET);

    // ****************************************
    // Ladder outputs
    // ****************************************
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            chan_out[i].code     = latch_q[i];
            chan_out[i].ladder   = ladder_code(latch_q[i],
                                   chan_uni(i, uni_a, uni_b));
            chan_out[i].zero     = zero_q[i];
            chan_out[i].gain     = gain_q[i];
            chan_out[i].gain4    = gain4_q[i];
            chan_out[i].unipolar = chan_uni(i, uni_a, uni_b);
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_gain_default: assert property (@(posedge mclk)
        rst_all |=> (gain4_q == 4'hF) throughout (!wr_cmd)[*1])
        else $error("gain bits not set after reset");

    a_reset_codes: assert property (@(posedge mclk)
        !rstn |=> (latch_q[0] == 12'h000 && input_q[3] == 12'h000
                   && zero_q[1] == 9'h000))
        else $error("reset values not loaded");

    a_sw_rst_self: assert property (@(posedge mclk) disable iff (!rstn)
        (wr_cmd && data[CMD_RST_BIT]) |=> sw_rst_q ##1 !sw_rst_q
        && in_reset)
        else $error("software reset did not self clear");

    a_no_frame_rst: assert property (@(posedge mclk)
        rst_all |-> !take)
        else $error("frame taken during reset");

    a_short_drop: assert property (@(posedge mclk) disable iff (rst_all)
        (cs_rise && !word_ok_q) |=> $stable(pend_q)
        && input_q[0] == $past(input_q[0]))
        else $error("short frame changed a register");

    a_load_clears: assert property (@(posedge mclk) disable iff (rst_all)
        (load_evt && !(|wr_in)) |=> (pend_q == 4'h0))
        else $error("pending flags left after load");

    a_load_copy: assert property (@(posedge mclk) disable iff (rst_all)
        (load_evt && pend_q[2] && !wr_in[2])
        |=> latch_q[2] == $past(input_q[2]))
        else $error("load did not copy pending code");

    a_latch_hold: assert property (@(posedge mclk) disable iff (rst_all)
        (!load_evt && !(|wr_in)) |=> $stable(latch_q[1]))
        else $error("latch changed without load");

    a_indiv_upd: assert property (@(posedge mclk) disable iff (rst_all)
        (wr_in[0] && !ld_f) |=> latch_q[0] == input_q[0]
        && !pend_q[0])
        else $error("individual update missed");

    a_pend_set: assert property (@(posedge mclk) disable iff (rst_all)
        (wr_in[3] && ld_f && !load_evt) |=> pend_q[3]
        && latch_q[3] == $past(latch_q[3]))
        else $error("simultaneous write touched latch");

    a_bip_format: assert property (@(posedge mclk) disable iff (rst_all)
        !uni_b |-> chan_out[2].ladder == (latch_q[2] ^ 12'h800))
        else $error("bipolar mapping wrong");

    a_ld_event: assert property (@(posedge mclk) disable iff (rst_all)
        $fell(ld_f) |-> load_evt)
        else $error("load pin fall missed");

    c_indiv: cover property (@(posedge mclk) disable iff (rst_all)
        wr_in[0] && !ld_f);
    c_pin_load: cover property (@(posedge mclk) disable iff (rst_all)
        ld_fall && (|pend_q));
    c_bit_load: cover property (@(posedge mclk) disable iff (rst_all)
        wr_cmd && data[CMD_LD_BIT] && (|pend_q));
    c_sw_reset: cover property (@(posedge mclk) disable iff (!rstn)
        sw_rst_q);

endmodule

// ### qdc_host_model.sv
// Host model for the serial link of the quad converter core.
// Assumes the caller spaces frames at least 150 ns apart.
`timescale 1ns/100ps
module qdc_host_model (
    output logic sclk,  // Link clock, stands high outside frames
    output logic cs_n,  // Frame select, active low
    output logic sdi    // Serial data
);
    // ********************************
    // Frame driver
    // ********************************
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end

    // Sends lead junk ones, then w from bit 23 down to bit cut
    task automatic send(input logic [23:0] w, input int lead,
                        input int cut);
        logic [25:0] f;
        f = {2'b11, w};
        cs_n = 1'b0;
        #5;
        for (int i = 23 + lead; i >= cut; i--) begin
            sdi = f[i];
            #15 sclk = 1'b0;
            #15 sclk = 1'b1;
        end
        #10 cs_n = 1'b1;
        // Released line must not keep showing the last bit
        sdi = ~sdi;
    endtask
endmodule

// ### tb.sv
// Self-checking bench of the quad converter core.
// Assumes the host model drives the link at a 30 ns period.
`timescale 1ns/100ps
module tb;
    import qdc_pkg::*;

    logic            mclk, rstn, load_strobe_n;
    logic            range_mode_a, range_mode_b;
    logic            sclk, cs_n, sdi, in_reset;
    qdc_chan_s [3:0] chan_out;
    qdc_rdbk_s       readback;
    int              err_count, num_checks, cyc;

    qdc_core qdc_core_inst (.mclk(mclk), .rstn(rstn), .sclk(sclk),
        .cs_n(cs_n), .sdi(sdi), .load_strobe_n(load_strobe_n),
        .range_mode_a(range_mode_a), .range_mode_b(range_mode_b),
        .chan_out(chan_out), .readback(readback), .in_reset(in_reset));
    qdc_host_model qdc_host_model_inst (.sclk(sclk), .cs_n(cs_n),
        .sdi(sdi));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ********************************
    // Helpers
    // ********************************
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic pin(input logic v);
        @(posedge mclk) load_strobe_n <= v;
        tick(4);
    endtask

    task automatic wr(input logic [3:0] a, input logic [11:0] d);
        qdc_host_model_inst.send({1'b0, a, 7'h00, d}, 0, 0);
        tick(10);
    endtask

    task automatic rd(input logic [3:0] a, input logic [11:0] exp);
        logic seen;
        seen = 1'b0;
        qdc_host_model_inst.send({1'b1, a, 7'h00, 12'h000}, 0, 0);
        for (int i = 0; i < 12 && !seen; i++) begin
            @(negedge mclk);
            seen = (readback.valid === 1'b1);
        end
        chk(seen, 1'b1);
        chk(readback.addr, a);
        chk(readback.data, exp);
        tick(6);
    endtask

    task automatic chk_reset();
        chk(in_reset, 1'b0);
        for (int c = 0; c < 4; c++) begin
            chk(chan_out[c].code, 16'h0000);
            chk(chan_out[c].zero, 16'h0000);
            chk(chan_out[c].gain, 16'h0000);
            chk(chan_out[c].gain4, 16'h0001);
        end
    endtask

    // ********************************
    // Hang guard
    // ********************************
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            give_verdict();
        end
    end

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        rstn          = 1'b0;
        load_strobe_n = 1'b1;
        range_mode_a  = 1'b1;
        range_mode_b  = 1'b0;
        err_count     = 0;
        num_checks    = 0;
        cyc           = 0;
        // Four reset edges; the pin filters have settled by then
        tick(4);
        rstn <= 1'b1;
        tick(4);
        chk_reset();
        chk(chan_out[0].unipolar, 1'b1);
        chk(chan_out[3].unipolar, 1'b0);
        // Deferred write, then load pin
        wr(4'h5, 12'hFFE);
        chk(chan_out[1].code, 16'h0000);
        pin(1'b0);
        tick(2);
        chk(chan_out[1].code, 16'h0FFE);
        chk(chan_out[1].ladder, 16'h0FFE);
        // Short frame dropped, long frame keeps last bits
        // If wrongly taken, the 23 bits would write 123h to channel 0
        qdc_host_model_inst.send(24'h400246, 0, 1);
        tick(10);
        chk(chan_out[0].code, 16'h0000);
        qdc_host_model_inst.send({12'h300, 12'h7FF}, 2, 0);
        tick(10);
        chk(chan_out[2].code, 16'h07FF);
        chk(chan_out[2].ladder, 16'h0FFF);
        pin(1'b1);
        // Load bit moves only the pending channel
        wr(4'h7, 12'h800);
        chk(chan_out[3].code, 16'h0000);
        wr(ADDR_CMD, 12'h10F);
        chk(chan_out[3].code, 16'h0800);
        chk(chan_out[3].ladder, 16'h0000);
        chk(chan_out[1].code, 16'h0FFE);
        // Trim limits and read-back
        wr(4'hC, 12'h080);
        wr(4'hD, 12'h07F);
        wr(4'hA, 12'h0FF);
        wr(4'hB, 12'h100);
        chk(chan_out[0].gain, 16'hFF80);
        chk(chan_out[1].gain, 16'h007F);
        chk(chan_out[2].zero, 16'h00FF);
        chk(chan_out[3].zero, 16'hFF00);
        rd(4'hC, 12'hF80);
        rd(4'hB, 12'hF00);
        rd(4'h6, 12'h7FF);
        // Action bits of the command word read back as zero
        rd(ADDR_CMD, 12'h00F);
        rd(4'h1, 12'h000);
        // Gain bits per channel
        wr(ADDR_CMD, 12'h005);
        for (int c = 0; c < 4; c++) begin
            chk(chan_out[c].gain4, ((c % 2) == 0));
        end
        // Group A to bipolar
        @(posedge mclk) range_mode_a <= 1'b0;
        tick(6);
        chk(chan_out[1].unipolar, 1'b0);
        chk(chan_out[1].ladder, 16'h07FE);
        // Software reset, then the bit must have cleared
        wr(ADDR_CMD, 12'h200);
        chk_reset();
        wr(ADDR_CMD, 12'h000);
        chk(in_reset, 1'b0);
        chk(chan_out[2].gain4, 1'b0);
        // Frame during hardware reset is ignored
        @(posedge mclk) rstn <= 1'b0;
        tick(2);
        wr(4'h4, 12'h555);
        @(posedge mclk) rstn <= 1'b1;
        tick(10);
        chk_reset();
        pin(1'b0);
        wr(4'h4, 12'h321);
        chk(chan_out[0].code, 16'h0321);
        pin(1'b1);
        give_verdict();
    end
endmodule
